// *** design/rptune_regs.sv ***
// Purpose: tuning register bank of one repeater port, driving static codes
// Assumes: the serial target presents one-cycle read and write strobes
// Notes:   a defaults load replaces every register with its factory value
//
// Overview of operation
// - bits 7-4 of the legacy register hold the disconnect threshold code, reset 8h.
// - bits 2-0 of the legacy register hold the squelch threshold code, reset 3h.
// - a factory one-time-programmable value may replace each register's reset default.
// - bits 7-5 of the pre-emphasis register hold the emphasis level, reset 0h.
// - bits 4-3 of the pre-emphasis register hold the emphasis width, reset 0h.
// - bit 0 of the pre-emphasis register enables charger detection, reset 0.
// - detection starts only with the enable set and a connection announced by the host.
// - when a detection attempt finishes the legacy-bus pull-up is turned on.
// - bit 6 of the transmit adjust register disables autoresume, reset 0.
// - bits 4-3 of the transmit adjust register hold the edge rate code, reset 1h.
// - bits 2-0 of the transmit adjust register hold the swing code, reset 3h.
// - bits 6-4 of the receive adjust register hold the squelch code, reset 6h.
// - bits 3-0 of the receive adjust register hold the receive boost code, reset 0h.
module rptune_regs (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // register access from the serial target
    input  wire rptune_pkg::rptune_byte_type reg_addr,
    input  wire logic                  reg_write,
    input  wire rptune_pkg::rptune_byte_type reg_wdata,
    input  wire logic                  reg_read,
    output rptune_pkg::rptune_byte_type reg_rdata,
    output logic                       reg_rvalid,
    // factory defaults load
    input  wire logic                  otp_load,
    input  wire rptune_pkg::rptune_byte_type otp_legacy_disconnect_squelch,
    input  wire rptune_pkg::rptune_byte_type otp_embedded_pre_emphasis,
    input  wire rptune_pkg::rptune_byte_type otp_embedded_tx_adjust,
    input  wire rptune_pkg::rptune_byte_type otp_embedded_rx_adjust,
    // legacy side codes
    output logic [3:0]                 legacy_disconnect_level,
    output logic [2:0]                 legacy_squelch_level,
    // embedded side transmit codes
    output logic [2:0]                 embedded_emphasis_level,
    output logic [1:0]                 embedded_emphasis_width,
    output logic [1:0]                 embedded_edge_rate,
    output logic [2:0]                 embedded_tx_swing,
    output logic                       autoresume_disable,
    // embedded side receive codes
    output logic [2:0]                 embedded_squelch_level,
    output logic [3:0]                 embedded_rx_boost,
    // charger detection
    input  wire logic                  peripheral_mode,
    input  wire logic                  soc_connect,
    input  wire logic                  detect_done,
    output logic                       charger_detect_enable,
    output logic                       detect_active,
    output logic                       pullup_enable
);
    import rptune_pkg::*;

    // decoded access: hit flag and register index
    typedef struct packed {
        logic           hit;
        rptune_idx_type idx;
    } rptune_decode_type;

    // register storage, addressed by index
    rptune_byte_type tune_reg      [RPT_NUM_REGS];
    rptune_byte_type next_tune_reg [RPT_NUM_REGS];
    rptune_byte_type otp_value     [RPT_NUM_REGS];

    // read answer
    rptune_byte_type   next_reg_rdata;
    logic              next_reg_rvalid;
    rptune_decode_type wr_dec;
    rptune_decode_type rd_dec;

    // offset to index; shared by the write and read paths
    function automatic rptune_decode_type decode_offset(input rptune_byte_type addr);
        rptune_decode_type result;
        result.hit = 1'b0;
        result.idx = '0;
        for (int i = 0; i < RPT_NUM_REGS; i++) begin
            if (addr == RPT_OFFSET[i]) begin
                result.hit = 1'b1;
                result.idx = rptune_idx_type'(i);
            end
        end
        return result;
    endfunction

    // factory values gathered in index order
    always_comb begin
        otp_value[IDX_LEGACY_DS] = otp_legacy_disconnect_squelch;
        otp_value[IDX_EMPHASIS]  = otp_embedded_pre_emphasis;
        otp_value[IDX_TX_ADJUST] = otp_embedded_tx_adjust;
        otp_value[IDX_RX_ADJUST] = otp_embedded_rx_adjust;
    end

    assign wr_dec = decode_offset(reg_addr);
    assign rd_dec = decode_offset(reg_addr);

    // next register values; a defaults load overrides a write in the same
    // cycle, since software cannot expect a write to survive a reload
    always_comb begin
        for (int i = 0; i < RPT_NUM_REGS; i++) begin
            next_tune_reg[i] = tune_reg[i];
        end
        if (otp_load) begin
            for (int i = 0; i < RPT_NUM_REGS; i++) begin
                next_tune_reg[i] = otp_value[i] & RPT_MASK[i];
            end
        end else if (reg_write && wr_dec.hit) begin
            next_tune_reg[wr_dec.idx] = reg_wdata & RPT_MASK[wr_dec.idx];
        end
    end

    // one storage flop group per register, reset to its hardware default
    generate
        for (genvar g = 0; g < RPT_NUM_REGS; g++) begin : g_reg
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    tune_reg[g] <= RPT_RESET[g];
                end else begin
                    tune_reg[g] <= next_tune_reg[g];
                end
            end
        end
    endgenerate

    // read answer, one cycle after the strobe; unmapped offsets read zero
    always_comb begin
        next_reg_rvalid = reg_read;
        next_reg_rdata  = reg_rdata;
        if (reg_read) begin
            next_reg_rdata = rd_dec.hit ? tune_reg[rd_dec.idx] : RPT_UNMAPPED_DATA;
        end
    end

    // read answer flops; data holds until the next read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= RPT_UNMAPPED_DATA;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

    // legacy side static codes, straight from the storage flops
    assign legacy_disconnect_level =
        tune_reg[IDX_LEGACY_DS][LEGACY_DISC_LSB +: LEGACY_DISC_WIDTH];
    assign legacy_squelch_level    =
        tune_reg[IDX_LEGACY_DS][LEGACY_SQ_LSB +: LEGACY_SQ_WIDTH];

    // embedded side transmit codes and the charger detection enable
    assign embedded_emphasis_level =
        tune_reg[IDX_EMPHASIS][EMPH_LEVEL_LSB +: EMPH_LEVEL_WIDTH];
    assign embedded_emphasis_width =
        tune_reg[IDX_EMPHASIS][EMPH_WIDTH_LSB +: EMPH_WIDTH_WIDTH];
    assign charger_detect_enable   = tune_reg[IDX_EMPHASIS][CHG_ENABLE_BIT];
    assign autoresume_disable      = tune_reg[IDX_TX_ADJUST][AUTORESUME_OFF_BIT];
    assign embedded_edge_rate      =
        tune_reg[IDX_TX_ADJUST][EDGE_RATE_LSB +: EDGE_RATE_WIDTH];
    assign embedded_tx_swing       =
        tune_reg[IDX_TX_ADJUST][TX_SWING_LSB +: TX_SWING_WIDTH];

    // embedded side receive codes
    assign embedded_squelch_level  =
        tune_reg[IDX_RX_ADJUST][EMB_SQ_LSB +: EMB_SQ_WIDTH];
    assign embedded_rx_boost       =
        tune_reg[IDX_RX_ADJUST][RX_BOOST_LSB +: RX_BOOST_WIDTH];

    // detection sequencing; clearing the enable mid-attempt ends it early
    rptune_charger_ctl u_charger (
        .clock           (clock),
        .rst_b           (rst_b),
        .detect_enable   (tune_reg[IDX_EMPHASIS][CHG_ENABLE_BIT]),
        .peripheral_mode (peripheral_mode),
        .soc_connect     (soc_connect),
        .detect_done     (detect_done),
        .detect_active   (detect_active),
        .pullup_enable   (pullup_enable)
    );

endmodule // rptune_regs

// *** pkg/rptune_pkg.sv ***
// Purpose: constants and types shared by the repeater port tuning register bank
// Assumes: byte-wide registers at byte offsets on the internal target port
// Notes:   arrays are indexed by the register index constants below
package rptune_pkg;

    // register count and index of each register in the bank
    localparam int unsigned RPT_NUM_REGS   = 4;
    localparam int unsigned RPT_IDX_WIDTH  = 2;
    localparam int unsigned IDX_LEGACY_DS  = 0;
    localparam int unsigned IDX_EMPHASIS   = 1;
    localparam int unsigned IDX_TX_ADJUST  = 2;
    localparam int unsigned IDX_RX_ADJUST  = 3;

    typedef logic [7:0] rptune_byte_type;
    typedef logic [RPT_IDX_WIDTH-1:0] rptune_idx_type;

    // byte offsets, in index order
    localparam rptune_byte_type RPT_OFFSET [RPT_NUM_REGS] = '{8'h73, 8'h77, 8'h78, 8'h79};
    // hardware reset defaults, in index order
    localparam rptune_byte_type RPT_RESET  [RPT_NUM_REGS] = '{8'h83, 8'h00, 8'h0B, 8'h60};
    // implemented bits; reserved bits are held at zero
    localparam rptune_byte_type RPT_MASK   [RPT_NUM_REGS] = '{8'hF7, 8'hF9, 8'h5F, 8'h7F};
    // value returned for an unmapped offset
    localparam rptune_byte_type RPT_UNMAPPED_DATA = 8'h00;

    // legacy disconnect / squelch register fields
    localparam int unsigned LEGACY_DISC_LSB    = 4;
    localparam int unsigned LEGACY_DISC_WIDTH  = 4;
    localparam int unsigned LEGACY_SQ_LSB      = 0;
    localparam int unsigned LEGACY_SQ_WIDTH    = 3;
    // embedded pre-emphasis register fields
    localparam int unsigned EMPH_LEVEL_LSB     = 5;
    localparam int unsigned EMPH_LEVEL_WIDTH   = 3;
    localparam int unsigned EMPH_WIDTH_LSB     = 3;
    localparam int unsigned EMPH_WIDTH_WIDTH   = 2;
    localparam int unsigned CHG_ENABLE_BIT     = 0;
    // embedded transmit adjust register fields
    localparam int unsigned AUTORESUME_OFF_BIT = 6;
    localparam int unsigned EDGE_RATE_LSB      = 3;
    localparam int unsigned EDGE_RATE_WIDTH    = 2;
    localparam int unsigned TX_SWING_LSB       = 0;
    localparam int unsigned TX_SWING_WIDTH     = 3;
    // embedded receive adjust register fields
    localparam int unsigned EMB_SQ_LSB         = 4;
    localparam int unsigned EMB_SQ_WIDTH       = 3;
    localparam int unsigned RX_BOOST_LSB       = 0;
    localparam int unsigned RX_BOOST_WIDTH     = 4;

    // charger detection sequence, gray coded along idle -> detect -> done
    typedef enum logic [1:0] {
        CHG_IDLE   = 2'b00,
        CHG_DETECT = 2'b01,
        CHG_DONE   = 2'b11
    } rptune_chg_state_type;

endpackage : rptune_pkg

// *** design/rptune_charger_ctl.sv ***
// Purpose: charger detection sequencing and connection pull-up control
// Assumes: analog front end reports the end of a detection attempt on detect_done
// Notes:   outputs are registered decodes of the state
module rptune_charger_ctl (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // controls
    input  wire logic detect_enable,
    input  wire logic peripheral_mode,
    input  wire logic soc_connect,
    input  wire logic detect_done,
    // to the analog front end
    output logic      detect_active,
    output logic      pullup_enable
);
    import rptune_pkg::*;

    rptune_chg_state_type state;
    rptune_chg_state_type next_state;
    logic                 next_detect_active;
    logic                 next_pullup_enable;

    // next state; losing the connection or the mode always returns to idle
    always_comb begin
        next_state = state;
        unique case (state)
            CHG_IDLE: begin
                if (peripheral_mode && soc_connect) begin
                    next_state = detect_enable ? CHG_DETECT : CHG_DONE;
                end
            end
            CHG_DETECT: begin
                if (!peripheral_mode || !soc_connect) begin
                    next_state = CHG_IDLE;
                end else if (detect_done || !detect_enable) begin
                    next_state = CHG_DONE;
                end
            end
            CHG_DONE: begin
                if (!peripheral_mode || !soc_connect) begin
                    next_state = CHG_IDLE;
                end
            end
            default: begin
                next_state = CHG_IDLE;
            end
        endcase
        next_detect_active = (next_state == CHG_DETECT);
        next_pullup_enable = (next_state == CHG_DONE);
    end

    // state and output flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state         <= CHG_IDLE;
            detect_active <= 1'b0;
            pullup_enable <= 1'b0;
        end else begin
            state         <= next_state;
            detect_active <= next_detect_active;
            pullup_enable <= next_pullup_enable;
        end
    end

endmodule // rptune_charger_ctl

// *** verif/rptune_afe_model.sv ***
// Purpose: analog front end stand-in that ends each charger detection attempt
// Assumes: an attempt runs while detect_active is high
// Notes:   lag sets how many cycles the front end takes to answer
module rptune_afe_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // detection handshake
    input  wire logic       detect_active,
    input  wire logic [3:0] lag,
    output logic            detect_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] count;
    logic [3:0] next_count;
    // count cycles of a running attempt; lag zero answers at once
    always_comb begin
        next_count = detect_active ? count + 4'h1 : 4'h0;
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            count <= 4'h0;
        else
            count <= next_count;
    end
    // done is only shown inside an attempt, never left standing
    assign detect_done = detect_active && (count >= lag);
endmodule // rptune_afe_model

// *** verif/rptune_regs_assertions.sv ***
// Purpose: port-level checks of the repeater port tuning registers
// Assumes: one clock domain, async active-low reset
// Notes:   write checks skip the cycle where a factory load wins
module rptune_regs_assertions (
    // clock and reset
    input wire logic                       clock,
    input wire logic                       rst_b,
    // register access and factory load
    input wire rptune_pkg::rptune_byte_type reg_addr,
    input wire logic                       reg_write,
    input wire rptune_pkg::rptune_byte_type reg_wdata,
    input wire logic                       reg_read,
    input wire rptune_pkg::rptune_byte_type reg_rdata,
    input wire logic                       reg_rvalid,
    input wire logic                       otp_load,
    input wire rptune_pkg::rptune_byte_type otp_legacy_disconnect_squelch,
    // codes and charger detection
    input wire logic [3:0]                 legacy_disconnect_level,
    input wire logic                       autoresume_disable,
    input wire logic [3:0]                 embedded_rx_boost,
    input wire logic                       charger_detect_enable,
    input wire logic                       peripheral_mode,
    input wire logic                       soc_connect,
    input wire logic                       detect_done,
    input wire logic                       detect_active,
    input wire logic                       pullup_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    import rptune_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // a write that is not overridden by a load
    logic wr_ok;
    assign wr_ok = reg_write && !otp_load;
    read_strobe_a: assert property (reg_rvalid == $past(reg_read))
        else $error("read answer not one cycle after strobe");
    reserved_zero_a: assert property (reg_rvalid && $past(reg_addr) == 8'h73 |->
        !reg_rdata[3])
        else $error("reserved bit reads back set");
    disc_write_a: assert property (wr_ok && reg_addr == 8'h73 |=>
        {legacy_disconnect_level, 4'h0} == ($past(reg_wdata) & 8'hF0))
        else $error("disconnect level not taken from write");
    chg_write_a: assert property (wr_ok && reg_addr == 8'h77 |=>
        {7'h00, charger_detect_enable} == ($past(reg_wdata) & 8'h01))
        else $error("detect enable not taken from write");
    resume_write_a: assert property (wr_ok && reg_addr == 8'h78 |=>
        {1'b0, autoresume_disable, 6'h00} == ($past(reg_wdata) & 8'h40))
        else $error("autoresume bit not taken from write");
    otp_load_a: assert property (otp_load |=>
        {legacy_disconnect_level, 4'h0} == ($past(otp_legacy_disconnect_squelch) & 8'hF0))
        else $error("factory load not applied");
    detect_gate_a: assert property ($rose(detect_active) |->
        $past(charger_detect_enable) && $past(soc_connect) && $past(peripheral_mode))
        else $error("detection started without enable and connect");
    pullup_after_a: assert property (detect_active && detect_done &&
        soc_connect && peripheral_mode |=> pullup_enable)
        else $error("pull-up not on after detection");
    boost_hold_a: assert property (!reg_write && !otp_load |=> $stable(embedded_rx_boost))
        else $error("boost code moved without a write");
endmodule // rptune_regs_assertions
bind rptune_regs rptune_regs_assertions u_chk (.clock, .rst_b, .reg_addr, .reg_write, .reg_wdata,
    .reg_read, .reg_rdata, .reg_rvalid, .otp_load, .otp_legacy_disconnect_squelch,
    .legacy_disconnect_level, .autoresume_disable, .embedded_rx_boost, .charger_detect_enable,
    .peripheral_mode, .soc_connect, .detect_done, .detect_active, .pullup_enable);

// *** verif/rptune_regs_bench.sv ***
// Purpose: self-checking bench of the repeater port tuning registers
// Assumes: read answer one cycle after the strobe, fields one cycle after a write
// Notes:   all four factory inputs share one driven value
module rptune_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rptune_pkg::*;
    logic clock = 0, rst_b = 0, reg_write = 0, reg_read = 0, otp_load = 0;
    logic peripheral_mode = 0, soc_connect = 0, detect_done, reg_rvalid, detect_active;
    logic pullup_enable, charger_detect_enable, autoresume_disable;
    rptune_byte_type reg_addr = 8'h00, reg_wdata = 8'h00, otp_v = 8'h00, reg_rdata;
    logic [3:0] legacy_disconnect_level, embedded_rx_boost, lag = 4'h0;
    logic [2:0] legacy_squelch_level, embedded_emphasis_level, embedded_tx_swing;
    logic [2:0] embedded_squelch_level;
    logic [1:0] embedded_emphasis_width, embedded_edge_rate;
    int miscompares = 0, comparisons = 0;
    always #2 clock = ~clock;
    rptune_regs u_dut (.clock, .rst_b, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata,
        .reg_rvalid, .otp_load, .otp_legacy_disconnect_squelch(otp_v),
        .otp_embedded_pre_emphasis(otp_v), .otp_embedded_tx_adjust(otp_v),
        .otp_embedded_rx_adjust(otp_v), .legacy_disconnect_level, .legacy_squelch_level,
        .embedded_emphasis_level, .embedded_emphasis_width, .embedded_edge_rate,
        .embedded_tx_swing, .autoresume_disable, .embedded_squelch_level, .embedded_rx_boost,
        .peripheral_mode, .soc_connect, .detect_done, .charger_detect_enable, .detect_active,
        .pullup_enable);
    rptune_afe_model u_afe (.clock, .rst_b, .detect_active, .lag, .detect_done);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one write strobe; fields are settled when this returns
    task automatic wr(input rptune_byte_type a, input rptune_byte_type d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input rptune_byte_type a, input rptune_byte_type e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, e);
    endtask
    // fields regrouped in register order, then read back
    task automatic expect_all(input rptune_byte_type a, b, c, d);
        chk({legacy_disconnect_level, 1'b0, legacy_squelch_level}, a);
        chk({embedded_emphasis_level, embedded_emphasis_width, 2'b00,
             charger_detect_enable}, b);
        chk({1'b0, autoresume_disable, 1'b0, embedded_edge_rate,
             embedded_tx_swing}, c);
        chk({1'b0, embedded_squelch_level, embedded_rx_boost}, d);
        rd(8'h73, a);
        rd(8'h77, b);
        rd(8'h78, c);
        rd(8'h79, d);
    endtask
    // bounded wait for detection (0) or pull-up (1)
    task automatic wait_hi(input int sel);
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clock);
            #1;
            if ((sel == 0 ? detect_active : pullup_enable) === 1'b1)
                break;
        end
        if (n == 40) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic t_write();
        rptune_byte_type d;
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'hFF : (k == 1) ? 8'hA5 : 8'h00;
            wr(8'h73, d);
            wr(8'h77, d);
            wr(8'h78, d);
            wr(8'h79, d);
            wr(8'h5A, ~d); // unmapped, must change nothing
            expect_all(d & 8'hF7, d & 8'hF9, d & 8'h5F, d & 8'h7F);
        end
        rd(8'h5A, 8'h00);
        // read and write in one cycle: the read still sees the old byte
        @(posedge clock);
        reg_write <= 1'b1;
        reg_read <= 1'b1;
        reg_addr <= 8'h79;
        reg_wdata <= 8'h15;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, 8'h00);
        chk({1'b0, embedded_squelch_level, embedded_rx_boost}, 8'h15);
    endtask
    // factory load beats a same-cycle write
    task automatic t_otp();
        @(posedge clock);
        otp_v <= 8'h6E;
        otp_load <= 1'b1;
        reg_write <= 1'b1;
        reg_addr <= 8'h73;
        reg_wdata <= 8'h00;
        @(posedge clock);
        otp_load <= 1'b0;
        reg_write <= 1'b0;
        #1;
        expect_all(8'h6E & 8'hF7, 8'h6E & 8'hF9, 8'h6E & 8'h5F, 8'h6E & 8'h7F);
    endtask
    task automatic t_charger();
        wr(8'h77, 8'h01);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            lag <= k ? 4'h9 : 4'h0;
            peripheral_mode <= 1'b1;
            soc_connect <= 1'b1;
            wait_hi(0);
            chk({7'h00, pullup_enable}, 8'h00);
            wait_hi(1);
            chk({7'h00, detect_active}, 8'h00);
            @(posedge clock);
            soc_connect <= 1'b0;
            @(posedge clock);
            #1;
            chk({6'h00, detect_active, pullup_enable}, 8'h00);
        end
        // host connects outside peripheral mode: nothing starts
        @(posedge clock);
        peripheral_mode <= 1'b0;
        soc_connect <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        chk({6'h00, detect_active, pullup_enable}, 8'h00);
        // enable off: pull-up comes without any detection
        wr(8'h77, 8'h00);
        @(posedge clock);
        peripheral_mode <= 1'b1;
        wait_hi(1);
        chk({7'h00, detect_active}, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        expect_all(8'h83, 8'h00, 8'h0B, 8'h60);
        t_write();
        t_otp();
        t_charger();
        close_out();
    end
endmodule // rptune_regs_bench
